// File: rtl/ccpt_pkg.sv
// shared constants for the capture/compare/pwm timer
package ccpt_pkg;
   localparam int          CCPT_CNT_W   = 16;      // counter and channel value width
   localparam int          CCPT_PRE_W   = 6;       // prescaler width, divides up to 64
   localparam int          CCPT_NUM_CH  = 2;       // number of channels
   localparam logic [2:0]  CCPT_SEL_EXT = 3'h7;    // clock select code for the external pin
   localparam logic [15:0] CCPT_CNT_RST = 16'h0000; // counter value after reset or wrap
   localparam logic [15:0] CCPT_VAL_RST = 16'h0000; // channel value after reset
   // edge/level select codes: capture uses bit 0 rising, bit 1 falling
   localparam logic [1:0]  CCPT_ELS_OFF = 2'h0;    // pin not used by the channel
   localparam logic [1:0]  CCPT_ELS_TGL = 2'h1;    // compare: toggle; capture: rising
   localparam logic [1:0]  CCPT_ELS_CLR = 2'h2;    // compare: clear; capture: falling
   localparam logic [1:0]  CCPT_ELS_SET = 2'h3;    // compare: set; capture: both edges
   localparam int          CCPT_ELS_RISE = 0;      // capture rising-edge enable bit
   localparam int          CCPT_ELS_FALL = 1;      // capture falling-edge enable bit
endpackage

// File: rtl/ccpt_channel.sv
// one timer channel: input capture, output compare and toggle-on-overflow pwm
`timescale 1ns/10ps
module ccpt_channel
   import ccpt_pkg::*;
(
   input  wire logic                  i_sys_clk,   // system clock
   input  wire logic                  i_rstn,      // async reset, active low
   input  wire logic                  i_tick,      // counter advance enable
   input  wire logic                  i_ovf,       // counter at modulo on a tick
   input  wire logic [CCPT_CNT_W-1:0] i_count,     // current counter value
   input  wire logic [CCPT_CNT_W-1:0] i_cmp_val,   // compare value in force
   input  wire logic                  i_pin_sync,  // synchronised pin level
   input  wire logic                  i_halt,      // counter halted
   input  wire logic                  i_enable,    // channel in use
   input  wire logic                  i_capture,   // 1 capture, 0 compare
   input  wire logic [1:0]            i_els,       // edge/level select
   input  wire logic                  i_tov,       // toggle on overflow
   input  wire logic                  i_irq_en,    // channel interrupt enable
   input  wire logic                  i_wr,        // value write strobe
   input  wire logic [CCPT_CNT_W-1:0] i_wr_data,   // value write data
   input  wire logic                  i_flag_clr,  // flag clear strobe
   output logic      [CCPT_CNT_W-1:0] o_val,       // channel value register
   output logic                       o_flag,      // channel event flag
   output logic                       o_irq,       // interrupt request
   output logic                       o_pin,       // pin output level
   output logic                       o_pin_oe     // pin output enable
);
   logic pin_d_ff;
   logic rise;
   logic fall;
   logic cap_hit;
   logic match;
   logic [CCPT_CNT_W-1:0] cnt_next;
   logic cmp_mode;
   logic nxt_flag;

   // edge detection on the already synchronised pin
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pin_d_ff <= 1'b0;
      end else begin
         pin_d_ff <= i_pin_sync;
      end
   end

   assign rise     = i_pin_sync & ~pin_d_ff;
   assign fall     = ~i_pin_sync & pin_d_ff;
   assign cmp_mode = i_enable & ~i_capture;
   // halted counter blocks captures so a stale time is never latched
   assign cap_hit  = i_enable & i_capture & ~i_halt &
                     ((i_els[CCPT_ELS_RISE] & rise) | (i_els[CCPT_ELS_FALL] & fall));
   // match as the counter arrives at the value, so overflow to match spans exactly the value
   assign cnt_next = i_ovf ? CCPT_CNT_RST : i_count + 1'b1;
   assign match    = cmp_mode & i_tick & (cnt_next == i_cmp_val);
   // set wins over a clear in the same cycle
   assign nxt_flag = (cap_hit | match) ? 1'b1 : (i_flag_clr ? 1'b0 : o_flag);

   // value register: capture latches the counter, else software writes land at once
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_val <= CCPT_VAL_RST;
      end else if (cap_hit) begin
         o_val <= i_count;
      end else if (i_wr) begin
         o_val <= i_wr_data;
      end
   end

   // flag and interrupt request
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_flag <= 1'b0;
         o_irq  <= 1'b0;
      end else begin
         o_flag <= nxt_flag;
         o_irq  <= nxt_flag & i_irq_en;
      end
   end

   // compare pin: overflow toggle first, so a pwm period edge is never lost
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_pin    <= 1'b0;
         o_pin_oe <= 1'b0;
      end else begin
         o_pin_oe <= cmp_mode & (i_els != CCPT_ELS_OFF);
         if (cmp_mode && i_tov && i_ovf && i_els != CCPT_ELS_OFF) begin
            o_pin <= ~o_pin;
         end else if (match) begin
            case (i_els)
               CCPT_ELS_TGL: o_pin <= ~o_pin;
               CCPT_ELS_CLR: o_pin <= 1'b0;
               CCPT_ELS_SET: o_pin <= 1'b1;
               default:      o_pin <= o_pin;
            endcase
         end
      end
   end

   a_cap_latch: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      cap_hit |=> o_val == $past(i_count)) else $error("capture did not latch counter");
   a_wr_direct: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (i_wr && !cap_hit) |=> o_val == $past(i_wr_data)) else $error("write not applied");
   a_cmp_set: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (match && i_els == CCPT_ELS_SET && !(i_tov && i_ovf)) |=> o_pin)
      else $error("compare set missed");
   a_ovf_toggle: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (cmp_mode && i_tov && i_ovf && i_els != CCPT_ELS_OFF) |=> o_pin != $past(o_pin))
      else $error("overflow toggle missed");
   a_event_irq: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      ((cap_hit || match) && i_irq_en) |=> (o_flag && o_irq)) else $error("event irq missing");
   a_halt_capture: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (i_halt && !i_wr) |=> $stable(o_val)) else $error("capture while halted");
endmodule

// File: rtl/ccpt_timer.sv
// capture/compare/pwm timer top: prescaler, counter, overflow, buffered pair
`timescale 1ns/10ps
module ccpt_timer
   import ccpt_pkg::*;
(
   input  wire logic                  i_sys_clk,         // 125 MHz system clock
   input  wire logic                  i_rstn,            // async reset, active low
   input  wire logic [2:0]            i_clk_div_sel,     // clock divider select
   input  wire logic                  i_ext_clk_pin,     // external timer clock pin
   input  wire logic                  i_halt_set,        // pulse: set counter halt
   input  wire logic                  i_halt_clr,        // pulse: clear counter halt
   input  wire logic                  i_cnt_reset,       // pulse: counter and prescaler to 0
   input  wire logic [CCPT_CNT_W-1:0] i_modulo,          // counter modulo value
   input  wire logic                  i_ovf_irq_en,      // overflow interrupt enable
   input  wire logic                  i_ovf_flag_clr,    // pulse: clear overflow flag
   input  wire logic                  i_buf_pair,        // link channels 0 and 1
   input  wire logic [1:0]            i_ch_capture,      // per channel: 1 capture, 0 compare
   input  wire logic [1:0]            i_ch0_els,         // channel 0 edge/level select
   input  wire logic [1:0]            i_ch1_els,         // channel 1 edge/level select
   input  wire logic [1:0]            i_ch_tov,          // per channel toggle on overflow
   input  wire logic [1:0]            i_ch_irq_en,       // per channel interrupt enable
   input  wire logic [1:0]            i_ch_wr,           // per channel value write strobe
   input  wire logic [CCPT_CNT_W-1:0] i_ch0_wr_data,     // channel 0 write data
   input  wire logic [CCPT_CNT_W-1:0] i_ch1_wr_data,     // channel 1 write data
   input  wire logic [1:0]            i_ch_flag_clr,     // per channel flag clear strobe
   input  wire logic [1:0]            i_ch_pin,          // channel pin levels
   output logic      [CCPT_CNT_W-1:0] o_count,           // counter value
   output logic                       o_counter_halt,    // counter halt bit
   output logic                       o_overflow_flag,   // overflow flag
   output logic                       o_ovf_irq,         // overflow interrupt request
   output logic                       o_ext_clk_input,   // external pin forced to input
   output logic                       o_buf_active,      // buffered pair: channel in control
   output logic      [CCPT_CNT_W-1:0] o_ch0_val,         // channel 0 value register
   output logic      [CCPT_CNT_W-1:0] o_ch1_val,         // channel 1 value register
   output logic      [1:0]            o_ch_flag,         // per channel event flag
   output logic      [1:0]            o_ch_irq,          // per channel interrupt request
   output logic      [1:0]            o_ch_pin,          // channel pin output levels
   output logic      [1:0]            o_ch_pin_oe        // channel pin output enables
);
   logic [CCPT_PRE_W-1:0] pre_ff;
   logic [CCPT_PRE_W-1:0] pre_mask;
   logic                  ext_s1_ff;
   logic                  ext_s2_ff;
   logic                  ext_d_ff;
   logic                  ext_rise;
   logic [1:0]            pin_s1_ff;
   logic [1:0]            pin_s2_ff;
   logic                  tick;
   logic                  ovf;
   logic                  last_wr_ff;
   logic                  nxt_last_wr;
   logic                  nxt_ovf_flag;
   logic [CCPT_CNT_W-1:0] ch_val    [CCPT_NUM_CH];
   logic [CCPT_CNT_W-1:0] ch_cmp    [CCPT_NUM_CH];
   logic [CCPT_CNT_W-1:0] ch_wdata  [CCPT_NUM_CH];
   logic [1:0]            ch_els    [CCPT_NUM_CH];
   logic [1:0]            ch_enable;

   // two-flop synchronisers for the external clock and the channel pins
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ext_s1_ff <= 1'b0;
         ext_s2_ff <= 1'b0;
         ext_d_ff  <= 1'b0;
         pin_s1_ff <= 2'h0;
         pin_s2_ff <= 2'h0;
      end else begin
         ext_s1_ff <= i_ext_clk_pin;
         ext_s2_ff <= ext_s1_ff;
         ext_d_ff  <= ext_s2_ff;
         pin_s1_ff <= i_ch_pin;
         pin_s2_ff <= pin_s1_ff;
      end
   end

   assign ext_rise = ext_s2_ff & ~ext_d_ff;

   // divide by 2^sel: tick when the low sel bits of the prescaler are all ones
   assign pre_mask = ~({CCPT_PRE_W{1'b1}} << i_clk_div_sel);
   assign tick     = ~o_counter_halt &
                     ((i_clk_div_sel == CCPT_SEL_EXT) ? ext_rise :
                      ((pre_ff & pre_mask) == pre_mask));
   assign ovf      = tick & (o_count == i_modulo);

   // prescaler only runs while the counter does, so halt freezes phase too
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pre_ff <= '0;
      end else if (i_cnt_reset) begin
         pre_ff <= '0;
      end else if (!o_counter_halt) begin
         pre_ff <= pre_ff + 1'b1;
      end
   end

   // halt bit: comes out of reset set, so the counter waits for software
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_counter_halt <= 1'b1;
      end else if (i_halt_clr) begin
         o_counter_halt <= 1'b0;
      end else if (i_halt_set) begin
         o_counter_halt <= 1'b1;
      end
   end

   // free-running up-counter, period is modulo plus one ticks
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_count <= CCPT_CNT_RST;
      end else if (i_cnt_reset) begin
         o_count <= CCPT_CNT_RST;
      end else if (tick) begin
         o_count <= ovf ? CCPT_CNT_RST : o_count + 1'b1;
      end
   end

   // overflow flag: a new overflow beats a clear arriving in the same cycle
   assign nxt_ovf_flag = ovf ? 1'b1 : (i_ovf_flag_clr ? 1'b0 : o_overflow_flag);
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_overflow_flag <= 1'b0;
         o_ovf_irq       <= 1'b0;
      end else begin
         o_overflow_flag <= nxt_ovf_flag;
         o_ovf_irq       <= nxt_ovf_flag & i_ovf_irq_en;
      end
   end

   // pin direction override while the external clock is selected
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_ext_clk_input <= 1'b0;
      end else begin
         o_ext_clk_input <= (i_clk_div_sel == CCPT_SEL_EXT);
      end
   end

   // buffered pair: the last written channel takes over at the next overflow;
   // writing the one in control behaves unbuffered, software must avoid it
   assign nxt_last_wr = i_ch_wr[1] ? 1'b1 : (i_ch_wr[0] ? 1'b0 : last_wr_ff);
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         last_wr_ff   <= 1'b0;
         o_buf_active <= 1'b0;
      end else if (!i_buf_pair) begin
         last_wr_ff   <= 1'b0;
         o_buf_active <= 1'b0;
      end else begin
         last_wr_ff <= nxt_last_wr;
         if (ovf) begin
            o_buf_active <= nxt_last_wr;
         end
      end
   end

   // channel wiring; in buffered mode channel 0 controls govern and channel 1 idles
   assign ch_wdata[0] = i_ch0_wr_data;
   assign ch_wdata[1] = i_ch1_wr_data;
   assign ch_els[0]   = i_ch0_els;
   assign ch_els[1]   = i_ch1_els;
   assign ch_enable   = {~i_buf_pair, 1'b1};
   assign ch_cmp[0]   = (i_buf_pair && o_buf_active) ? ch_val[1] : ch_val[0];
   assign ch_cmp[1]   = ch_val[1];
   assign o_ch0_val   = ch_val[0];
   assign o_ch1_val   = ch_val[1];

   // pwm duty is the compare value over modulo plus one, e.g. 0x0080 of 256
   genvar g;
   generate
      for (g = 0; g < CCPT_NUM_CH; g++) begin : g_ch
         ccpt_channel u_ch (
            .i_sys_clk  (i_sys_clk),
            .i_rstn     (i_rstn),
            .i_tick     (tick),
            .i_ovf      (ovf),
            .i_count    (o_count),
            .i_cmp_val  (ch_cmp[g]),
            .i_pin_sync (pin_s2_ff[g]),
            .i_halt     (o_counter_halt),
            .i_enable   (ch_enable[g]),
            .i_capture  (i_ch_capture[g]),
            .i_els      (ch_els[g]),
            .i_tov      (i_ch_tov[g]),
            .i_irq_en   (i_ch_irq_en[g]),
            .i_wr       (i_ch_wr[g]),
            .i_wr_data  (ch_wdata[g]),
            .i_flag_clr (i_ch_flag_clr[g]),
            .o_val      (ch_val[g]),
            .o_flag     (o_ch_flag[g]),
            .o_irq      (o_ch_irq[g]),
            .o_pin      (o_ch_pin[g]),
            .o_pin_oe   (o_ch_pin_oe[g])
         );
      end
   endgenerate

   a_halt_freeze: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (o_counter_halt && !i_cnt_reset) |=> $stable(o_count)) else $error("counter moved halted");
   a_ovf_wrap: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      ovf |=> (o_count == CCPT_CNT_RST && o_overflow_flag)) else $error("no wrap at modulo");
   a_ovf_irq: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (ovf && i_ovf_irq_en) |=> o_ovf_irq) else $error("overflow irq missing");
   a_ext_only: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (i_clk_div_sel == CCPT_SEL_EXT && !ext_rise) |-> !tick) else $error("tick without pin edge");
   a_div_two: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (i_clk_div_sel == 3'h1 && tick && $stable(i_clk_div_sel) && !i_cnt_reset) |=> !tick)
      else $error("divide by two ticked twice");
   a_full_rate: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (i_clk_div_sel == 3'h0 && !o_counter_halt) |-> tick) else $error("full rate missed tick");
   a_buf_switch: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (i_buf_pair && ovf && (i_ch_wr[1] || (last_wr_ff && !i_ch_wr[0]))) |=> o_buf_active)
      else $error("buffer did not switch");
   a_pin1_free: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_buf_pair [*2] |-> !o_ch_pin_oe[1]) else $error("pin 1 driven while linked");
endmodule

// File: dv/ccpt_pin_model.sv
// far-side model: event sources on the channel pins and the external clock pin
`timescale 1ns/10ps
module ccpt_pin_model (
   input  wire logic       i_sys_clk,  // bench clock, used for pacing only
   input  wire logic [1:0] i_pin_out,  // timer pin drive levels
   input  wire logic [1:0] i_pin_oe,   // timer pin drive enables
   output logic      [1:0] o_pin,      // resolved pin levels
   output logic            o_ext_clk   // external timer clock
);
   logic [1:0] src_ff;  // levels this model puts on undriven pins
   // the timer wins where it drives; otherwise the external source sets the level
   assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & src_ff);
   initial begin
      src_ff    = 2'h0;
      o_ext_clk = 1'b0;
   end
   // each level holds 4 cycles, above the minimum pulse width the sampler needs
   task automatic drive_pin(input int ch, input logic lvl);
      @(negedge i_sys_clk);
      src_ff[ch] = lvl;
      repeat (4) @(negedge i_sys_clk);
   endtask
   // bursts of clock pulses; the line rests low between bursts
   task automatic ext_pulses(input int n);
      repeat (n) begin
         o_ext_clk = 1'b1;
         repeat (3) @(negedge i_sys_clk);
         o_ext_clk = 1'b0;
         repeat (3) @(negedge i_sys_clk);
      end
   endtask
endmodule

// File: dv/ccpt_timer_tb_top.sv
// self-checking bench for the capture/compare/pwm timer
`timescale 1ns/10ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module ccpt_timer_tb_top;
   import ccpt_pkg::*;
   logic        clk, rstn, hset, hclr, crst, oen, oclr, bufp, ext, halt, oflag, oirq, extin, bact;
   logic [2:0]  sel;
   logic [15:0] modv, wd0, wd1, cnt, v0, v1;
   logic [1:0]  cap, els0, els1, tov, ien, wr, fclr, pin, flag, irq, pout, poe;
   int          err_count, n_compared, h, c;
   ccpt_timer dut (.i_sys_clk(clk), .i_rstn(rstn), .i_clk_div_sel(sel), .i_ext_clk_pin(ext),
      .i_halt_set(hset), .i_halt_clr(hclr), .i_cnt_reset(crst), .i_modulo(modv),
      .i_ovf_irq_en(oen), .i_ovf_flag_clr(oclr), .i_buf_pair(bufp), .i_ch_capture(cap),
      .i_ch0_els(els0), .i_ch1_els(els1), .i_ch_tov(tov), .i_ch_irq_en(ien), .i_ch_wr(wr),
      .i_ch0_wr_data(wd0), .i_ch1_wr_data(wd1), .i_ch_flag_clr(fclr), .i_ch_pin(pin),
      .o_count(cnt), .o_counter_halt(halt), .o_overflow_flag(oflag), .o_ovf_irq(oirq),
      .o_ext_clk_input(extin), .o_buf_active(bact), .o_ch0_val(v0), .o_ch1_val(v1),
      .o_ch_flag(flag), .o_ch_irq(irq), .o_ch_pin(pout), .o_ch_pin_oe(poe));
   ccpt_pin_model u_pins (.i_sys_clk(clk), .i_pin_out(pout), .i_pin_oe(poe), .o_pin(pin),
      .o_ext_clk(ext));
   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // one-cycle strobes; both value buses carry the same word
   task automatic wr_ch(input int ch, input logic [15:0] d);
      @(negedge clk);
      wr[ch] = 1'b1; wd0 = d; wd1 = d;
      @(negedge clk);
      wr = 2'h0;
   endtask
   task automatic pulse(input int which);
      @(negedge clk);
      {hset, hclr, crst, oclr} = 4'h8 >> which;
      fclr = (which == 4) ? 2'h3 : 2'h0;
      @(negedge clk);
      {hset, hclr, crst, oclr, fclr} = 6'h00;
   endtask
   // bounded wait on a channel flag, 2000 cycles at most
   task automatic wait_flag(input int ch);
      for (c = 0; c < 2000 && flag[ch] !== 1'b1; c++) tick(1);
      if (c == 2000) begin
         err_count++;
         print_verdict();
      end
   endtask
   // clear the overflow flag, then bounded wait for the next overflow, 600 cycles at most
   task automatic wait_ovf;
      pulse(3);
      for (c = 0; c < 600 && oflag !== 1'b1; c++) tick(1);
      if (c == 600) begin
         err_count++;
         print_verdict();
      end
   endtask
   // high cycles on pin 0 over two 256-cycle periods
   task automatic high_time;
      h = 0;
      repeat (512) begin
         @(negedge clk);
         if (pout[0] === 1'b1) h++;
      end
   endtask
   task automatic print_verdict;
      $display("compared %0d mismatched %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // main sequence
   initial begin
      err_count = 0; n_compared = 0;
      rstn = 1'b0; {hset, hclr, crst, oen, oclr, bufp} = 6'h00; sel = 3'h0; modv = 16'hFFFF;
      {wd0, wd1} = 32'h0; {cap, els0, els1, tov, ien, wr, fclr} = 14'h0000;
      tick(12);
      rstn = 1'b1;
      tick(4);
      `CHK(halt, 1'b1)
      `CHK(cnt, CCPT_CNT_RST)
      pulse(1);
      for (int s = 0; s < 7; s++) begin
         sel = s[2:0];
         pulse(2);
         c = cnt;
         tick(64);
         `CHK(cnt - c[15:0], 16'h0040 >> s)
      end
      $display("test prescaler done");
      modv = 16'h000F; sel = 3'h0; oen = 1'b1;
      pulse(2); wait_ovf();
      `CHK(cnt, 16'h0000)
      `CHK(oirq, 1'b1)
      pulse(3);
      `CHK(oflag, 1'b0)
      $display("test overflow done");
      modv = 16'hFFFF; sel = CCPT_SEL_EXT; pulse(2);
      `CHK(extin, 1'b1)
      u_pins.ext_pulses(5); tick(4);
      `CHK(cnt, 16'h0005)
      // the frozen external clock holds the count, so the captured value is exact
      cap = 2'h2; els1 = CCPT_ELS_TGL; ien = 2'h2;
      u_pins.drive_pin(1, 1'b1); wait_flag(1); tick(1);
      `CHK(v1, 16'h0005)
      `CHK(irq[1], 1'b1)
      els1 = CCPT_ELS_CLR; u_pins.drive_pin(1, 1'b0); pulse(4); u_pins.ext_pulses(2);
      u_pins.drive_pin(1, 1'b1); tick(4);
      `CHK(flag[1], 1'b0)
      u_pins.drive_pin(1, 1'b0); wait_flag(1); tick(1);
      `CHK(v1, 16'h0007)
      els1 = CCPT_ELS_TGL; pulse(4); pulse(0); u_pins.drive_pin(1, 1'b1); tick(4);
      `CHK(flag[1], 1'b0)
      `CHK(v1, 16'h0007)
      $display("test capture done");
      cap = 2'h0; sel = 3'h0; modv = 16'h000F; ien = 2'h1; pulse(1); wr_ch(0, 16'h0005);
      `CHK(v0, 16'h0005)
      for (int e = 3; e > 0; e--) begin
         els0 = e[1:0]; pulse(4); wait_flag(0); tick(2);
         `CHK(pout[0], (e != 2))
         `CHK(poe[0], 1'b1)
         `CHK(irq[0], 1'b1)
      end
      $display("test compare done");
      // raise the value from the overflow routine so no period sees two compares
      modv = 16'h00FF; els0 = CCPT_ELS_CLR; tov = 2'h1; wait_ovf();
      wr_ch(0, 16'h0080); tick(300);
      high_time();
      `CHK(h, 256)
      // lower the value from the compare routine, ahead of the next overflow
      pulse(4); wait_flag(0); wr_ch(0, 16'h0040);
      high_time();
      `CHK(h, 128)
      $display("test pwm done");
      bufp = 1'b1; wr_ch(1, 16'h00C0); tick(300); // inactive channel only
      `CHK(bact, 1'b1)
      `CHK(poe[1], 1'b0)
      high_time();
      `CHK(h, 384)
      $display("test buffered done");
      print_verdict();
   end
endmodule
